// [gpio_pkg.sv]
// constants, register map and state types for the port four to six block
package gpio_pkg;
   // port width
   localparam int PORT_W = 8;
   // register indices; byte address is four times the index
   localparam logic [13:0] IDX_PORT4_LATCH = 14'h0004;
   localparam logic [13:0] IDX_PORT5_LATCH = 14'h0005;
   localparam logic [13:0] IDX_PORT6_LATCH = 14'h0006;
   localparam logic [13:0] IDX_PORT4_RMW = 14'h0014;
   localparam logic [13:0] IDX_PORT5_RMW = 14'h0015;
   localparam logic [13:0] IDX_PORT4_DRAIN = 14'h1f84;
   localparam logic [13:0] IDX_PORT5_DRAIN = 14'h1f85;
   localparam logic [13:0] IDX_PORT4_DIR = 14'h1f8a;
   localparam logic [13:0] IDX_PORT5_DIR = 14'h1f8b;
   localparam logic [13:0] IDX_PORT6_DIR = 14'h1f8c;
   localparam logic [13:0] IDX_ANALOG_CTRL = 14'h1f90;
   // field position of the analog disable flag
   localparam int ANALOG_DIS_BIT = 0;
   // values after reset
   localparam logic [7:0] RST_LATCH = 8'h00;
   localparam logic [7:0] RST_DIR = 8'h00;
   localparam logic [7:0] RST_DRAIN = 8'h00;
   localparam logic RST_ANALOG_DIS = 1'b1;
   localparam logic [31:0] RST_RDATA = 32'h0000_0000;
   // cycles from request to waitrequest low
   localparam int ANSWER_CYCLES = 1;

   // register state of the main block
   typedef struct packed {
      logic [7:0] p4_lat;
      logic [7:0] p4_dir;
      logic [7:0] p4_drn;
      logic [7:0] p5_lat;
      logic [7:0] p5_dir;
      logic [7:0] p5_drn;
      logic [7:0] p6_lat;
      logic [7:0] p6_dir;
      logic analog_dis;
      logic ack;
      logic [31:0] rdata;
   } regs_s;

   // synchroniser state
   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;
   } sync_s;
endpackage

// [pin_sync.sv]
// two-stage synchroniser for eight pin inputs
`timescale 1ns/1ns
module pin_sync (
   input wire logic core_clk_i, // system clock
   input wire logic srst_i, // synchronous reset, high
   input wire logic [7:0] pin_i, // raw pin levels
   output logic [7:0] sync_o // levels after two stages
);
   gpio_pkg::sync_s st_q;
   gpio_pkg::sync_s st_d;

   // first stage feeds only the second
   always_comb begin
      st_d = st_q;
      st_d.s1 = pin_i;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign sync_o = st_q.s2;

   // pin level reaches the output two edges later
   sync_delay_a: assert property (@(posedge core_clk_i) disable iff (srst_i)
      1'b1 ##2 !$past(srst_i, 2) |-> sync_o == $past(pin_i, 2))
      else $error("pin synchroniser delay is not two cycles");
endmodule

// [port_pad.sv]
// output stage of one eight-bit port: direction, latch, drain mode, shared function
`timescale 1ns/1ns
module port_pad (
   input wire logic [7:0] dir_i, // 1 = output mode
   input wire logic [7:0] lat_i, // output latch
   input wire logic [7:0] drn_i, // 1 = open drain
   input wire logic [7:0] func_en_i, // shared function owns the bit
   input wire logic [7:0] func_i, // shared function output level
   output logic [7:0] out_o, // level to drive
   output logic [7:0] oe_n_o // low while driving
);
   logic [7:0] val;

   // latch gates the shared function, so it must be 1 to pass it
   assign val = lat_i & (~func_en_i | func_i);
   assign out_o = val;
   // open drain drives only a low; input mode never drives
   assign oe_n_o = ~(dir_i & (~drn_i | ~val));
endmodule

// [gpio_ports_four_to_six.sv]
// three eight-bit general-purpose ports with an avalon-mm register slave
`timescale 1ns/1ns
module gpio_ports_four_to_six (
   input wire logic core_clk_i, // 100 MHz system clock
   input wire logic srst_i, // synchronous reset, high
   input wire logic [15:0] address_i, // avalon byte address
   input wire logic read_i, // avalon read
   input wire logic write_i, // avalon write
   input wire logic [31:0] writedata_i, // avalon write data
   input wire logic [3:0] byteenable_i, // avalon byte enables
   output logic [31:0] readdata_o, // avalon read data
   output logic waitrequest_o, // avalon wait
   input wire logic [7:0] port4_pin_i, // port four pin levels
   output logic [7:0] port4_pin_o, // port four drive levels
   output logic [7:0] port4_pin_oe_n_o, // port four enables, low drives
   input wire logic [7:0] port4_func_en_i, // serial/timer owns port four bit
   input wire logic [7:0] port4_func_i, // serial/timer output levels
   output logic [7:0] port4_in_o, // synced port four levels
   input wire logic [7:0] port5_pin_i, // port five pin levels
   output logic [7:0] port5_pin_o, // port five drive levels
   output logic [7:0] port5_pin_oe_n_o, // port five enables, low drives
   input wire logic [7:0] motor_control_output_en_i, // motor logic owns bit
   input wire logic [7:0] motor_control_output_i, // motor output levels
   output logic emergency_stop_two_o, // synced emergency input
   input wire logic [7:0] port6_pin_i, // port six pin levels
   output logic [7:0] port6_pin_o, // port six drive levels
   output logic [7:0] port6_pin_oe_n_o, // port six enables, low drives
   input wire logic debug_output_one_en_i, // debug output owns bit seven
   input wire logic debug_output_one_i, // debug output level
   output logic [7:0] analog_input_sel_o, // bits in analog input mode
   output logic analog_input_disable_o // analog disable flag
);
   gpio_pkg::regs_s r_q;
   gpio_pkg::regs_s r_d;
   logic [7:0] p4_sync;
   logic [7:0] p5_sync;
   logic [7:0] p6_sync;
   logic [7:0] p6_read;
   logic [7:0] p6_func_en;
   logic [7:0] p6_func;
   logic req;
   logic wr_take;

   // word decode: true when the byte address lands on an index
   function automatic logic hit(input logic [15:0] a, input logic [13:0] idx);
      hit = (a[15:2] == idx);
   endfunction

   // read view of a drain-capable port for rmw: latch on open-drain bits
   function automatic logic [7:0] rmw_view(input logic [7:0] pin, input logic [7:0] lat,
                                           input logic [7:0] drn);
      rmw_view = (drn & lat) | (~drn & pin);
   endfunction

   // byte-lane 0 merge of a write
   function automatic logic [7:0] wr8(input logic [7:0] old, input logic [31:0] wd,
                                      input logic [3:0] be);
      wr8 = be[0] ? wd[7:0] : old;
   endfunction

   // pin inputs, two stages each
   pin_sync u_sync4 (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .pin_i(port4_pin_i),
      .sync_o(p4_sync)
   );
   pin_sync u_sync5 (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .pin_i(port5_pin_i),
      .sync_o(p5_sync)
   );
   pin_sync u_sync6 (
      .core_clk_i(core_clk_i),
      .srst_i(srst_i),
      .pin_i(port6_pin_i),
      .sync_o(p6_sync)
   );

   // port six reads 0 unless output mode or latch set
   assign p6_read = p6_sync & (r_q.p6_dir | r_q.p6_lat);

   // bus handshake: one wait cycle, then the answer
   assign req = read_i | write_i;
   assign waitrequest_o = req & ~r_q.ack;
   assign wr_take = write_i & r_q.ack;

   // next-state of all registers
   always_comb begin
      r_d = r_q;
      r_d.ack = req & ~r_q.ack;
      // read data are latched in the wait cycle so they stand at the answer
      if (read_i & ~r_q.ack) begin
         r_d.rdata = '0;
         if (hit(address_i, gpio_pkg::IDX_PORT4_LATCH)) begin
            r_d.rdata[7:0] = p4_sync;
         end else if (hit(address_i, gpio_pkg::IDX_PORT5_LATCH)) begin
            r_d.rdata[7:0] = p5_sync;
         end else if (hit(address_i, gpio_pkg::IDX_PORT6_LATCH)) begin
            r_d.rdata[7:0] = p6_read;
         end else if (hit(address_i, gpio_pkg::IDX_PORT4_RMW)) begin
            r_d.rdata[7:0] = rmw_view(p4_sync, r_q.p4_lat, r_q.p4_drn);
         end else if (hit(address_i, gpio_pkg::IDX_PORT5_RMW)) begin
            r_d.rdata[7:0] = rmw_view(p5_sync, r_q.p5_lat, r_q.p5_drn);
         end else if (hit(address_i, gpio_pkg::IDX_PORT4_DRAIN)) begin
            r_d.rdata[7:0] = r_q.p4_drn;
         end else if (hit(address_i, gpio_pkg::IDX_PORT5_DRAIN)) begin
            r_d.rdata[7:0] = r_q.p5_drn;
         end else if (hit(address_i, gpio_pkg::IDX_PORT4_DIR)) begin
            r_d.rdata[7:0] = r_q.p4_dir;
         end else if (hit(address_i, gpio_pkg::IDX_PORT5_DIR)) begin
            r_d.rdata[7:0] = r_q.p5_dir;
         end else if (hit(address_i, gpio_pkg::IDX_PORT6_DIR)) begin
            r_d.rdata[7:0] = r_q.p6_dir;
         end else if (hit(address_i, gpio_pkg::IDX_ANALOG_CTRL)) begin
            r_d.rdata[gpio_pkg::ANALOG_DIS_BIT] = r_q.analog_dis;
         end
      end
      // writes take effect on the edge where waitrequest is low
      if (wr_take) begin
         if (hit(address_i, gpio_pkg::IDX_PORT4_LATCH)) begin
            r_d.p4_lat = wr8(r_q.p4_lat, writedata_i, byteenable_i);
         end else if (hit(address_i, gpio_pkg::IDX_PORT5_LATCH)) begin
            r_d.p5_lat = wr8(r_q.p5_lat, writedata_i, byteenable_i);
         end else if (hit(address_i, gpio_pkg::IDX_PORT6_LATCH)) begin
            r_d.p6_lat = wr8(r_q.p6_lat, writedata_i, byteenable_i);
         end else if (hit(address_i, gpio_pkg::IDX_PORT4_DRAIN)) begin
            r_d.p4_drn = wr8(r_q.p4_drn, writedata_i, byteenable_i);
         end else if (hit(address_i, gpio_pkg::IDX_PORT5_DRAIN)) begin
            r_d.p5_drn = wr8(r_q.p5_drn, writedata_i, byteenable_i);
         end else if (hit(address_i, gpio_pkg::IDX_PORT4_DIR)) begin
            r_d.p4_dir = wr8(r_q.p4_dir, writedata_i, byteenable_i);
         end else if (hit(address_i, gpio_pkg::IDX_PORT5_DIR)) begin
            r_d.p5_dir = wr8(r_q.p5_dir, writedata_i, byteenable_i);
         end else if (hit(address_i, gpio_pkg::IDX_PORT6_DIR)) begin
            r_d.p6_dir = wr8(r_q.p6_dir, writedata_i, byteenable_i);
         end else if (hit(address_i, gpio_pkg::IDX_ANALOG_CTRL) && byteenable_i[0]) begin
            r_d.analog_dis = writedata_i[gpio_pkg::ANALOG_DIS_BIT];
         end
      end
   end

   // register the state; reset puts every port in input mode
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         r_q.p4_lat <= gpio_pkg::RST_LATCH;
         r_q.p5_lat <= gpio_pkg::RST_LATCH;
         r_q.p6_lat <= gpio_pkg::RST_LATCH;
         r_q.p4_dir <= gpio_pkg::RST_DIR;
         r_q.p5_dir <= gpio_pkg::RST_DIR;
         r_q.p6_dir <= gpio_pkg::RST_DIR;
         r_q.p4_drn <= gpio_pkg::RST_DRAIN;
         r_q.p5_drn <= gpio_pkg::RST_DRAIN;
         r_q.analog_dis <= gpio_pkg::RST_ANALOG_DIS;
         r_q.ack <= 1'b0;
         r_q.rdata <= gpio_pkg::RST_RDATA;
      end else begin
         r_q <= r_d;
      end
   end

   assign readdata_o = r_q.rdata;

   // port four: serial and timer pins share the stage
   port_pad u_pad4 (
      .dir_i(r_q.p4_dir),
      .lat_i(r_q.p4_lat),
      .drn_i(r_q.p4_drn),
      .func_en_i(port4_func_en_i),
      .func_i(port4_func_i),
      .out_o(port4_pin_o),
      .oe_n_o(port4_pin_oe_n_o)
   );

   // port five: motor outputs pass only where the latch is 1
   port_pad u_pad5 (
      .dir_i(r_q.p5_dir),
      .lat_i(r_q.p5_lat),
      .drn_i(r_q.p5_drn),
      .func_en_i(motor_control_output_en_i),
      .func_i(motor_control_output_i),
      .out_o(port5_pin_o),
      .oe_n_o(port5_pin_oe_n_o)
   );

   // port six: no open drain, debug output one on bit seven
   assign p6_func_en = {debug_output_one_en_i, 7'h00};
   assign p6_func = {debug_output_one_i, 7'h00};
   port_pad u_pad6 (
      .dir_i(r_q.p6_dir),
      .lat_i(r_q.p6_lat),
      .drn_i(8'h00),
      .func_en_i(p6_func_en),
      .func_i(p6_func),
      .out_o(port6_pin_o),
      .oe_n_o(port6_pin_oe_n_o)
   );

   // analog mode needs input, cleared latch and flag low; output mode always wins
   assign analog_input_sel_o = ~r_q.p6_dir & ~r_q.p6_lat & {8{~r_q.analog_dis}};
   assign analog_input_disable_o = r_q.analog_dis;
   assign port4_in_o = p4_sync;
   assign emergency_stop_two_o = p5_sync[1];

   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);

   // a fresh request followed by its answer one cycle later
   sequence fresh_req;
      req && !r_q.ack;
   endsequence
   sequence answered;
      req && !waitrequest_o;
   endsequence

   bus_answer_a: assert property (fresh_req |=> answered)
      else $error("bus answer not one cycle after request");

   latch_write_a: assert property ((write_i && !waitrequest_o && byteenable_i[0]
         && address_i[15:2] == gpio_pkg::IDX_PORT5_LATCH) |=> r_q.p5_lat == $past(writedata_i[7:0]))
      else $error("port five latch write lost");

   input_no_drive_a: assert property (port4_pin_oe_n_o == (~r_q.p4_dir | (r_q.p4_drn & port4_pin_o)))
      else $error("port four enable does not follow direction");

   reset_inputs_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
         srst_i |=> r_q.p4_dir == 8'h00 && r_q.p5_dir == 8'h00 && port5_pin_oe_n_o == 8'hff)
      else $error("direction not cleared by reset");

   reset_latch_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
         srst_i |=> r_q.p4_lat == 8'h00 && r_q.p5_lat == 8'h00)
      else $error("latch not cleared by reset");

   open_drain_a: assert property ((r_q.p5_drn & r_q.p5_dir & port5_pin_o) == 8'h00
         || (port5_pin_oe_n_o & r_q.p5_drn & r_q.p5_dir & port5_pin_o) == (r_q.p5_drn & r_q.p5_dir & port5_pin_o))
      else $error("open drain bit drives a high level");

   reset_drain_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
         srst_i |=> r_q.p4_drn == 8'h00 && r_q.p5_drn == 8'h00)
      else $error("drain select not cleared by reset");

   rmw_view_a: assert property ((read_i && !waitrequest_o && address_i[15:2] == gpio_pkg::IDX_PORT5_RMW)
         |-> (readdata_o[7:0] & r_q.p5_drn) == (r_q.p5_lat & r_q.p5_drn))
      else $error("rmw read does not show open drain latch");

   port6_zero_a: assert property ((read_i && !waitrequest_o && address_i[15:2] == gpio_pkg::IDX_PORT6_LATCH
         && $stable(r_q.p6_dir) && $stable(r_q.p6_lat))
         |-> (readdata_o[7:0] & ~r_q.p6_dir & ~r_q.p6_lat) == 8'h00)
      else $error("port six latch-cleared input read non-zero");

   port6_output_a: assert property ((r_q.p6_dir & analog_input_sel_o) == 8'h00
         && (port6_pin_oe_n_o & r_q.p6_dir) == 8'h00)
      else $error("port six output bit not driving");

   analog_sel_a: assert property (!r_q.analog_dis |-> analog_input_sel_o == (~r_q.p6_dir & ~r_q.p6_lat))
      else $error("analog select does not follow latch");

   reset_port6_a: assert property (@(posedge core_clk_i) disable iff (1'b0)
         srst_i |=> r_q.analog_dis && r_q.p6_lat == 8'h00 && analog_input_sel_o == 8'h00)
      else $error("port six not in forced-low input after reset");

   // the rmw alias is read-only, so a write to it must leave port five alone
   alias_write_a: assert property ((write_i && !waitrequest_o && address_i[15:2] == gpio_pkg::IDX_PORT5_RMW)
         |=> $stable(r_q.p5_lat) && $stable(r_q.p5_dir) && $stable(r_q.p5_drn))
      else $error("write to rmw alias changed port five");

   // flag high keeps every port six bit out of analog mode
   analog_off_a: assert property (r_q.analog_dis |-> analog_input_sel_o == 8'h00)
      else $error("analog mode while disable flag set");

   // a port six input bit never drives its pin
   port6_input_a: assert property ((port6_pin_oe_n_o | r_q.p6_dir) == 8'hff)
      else $error("port six input bit drives its pin");

   // the analog flag follows a write on the answer edge
   ctrl_write_a: assert property ((write_i && !waitrequest_o && byteenable_i[0]
         && address_i[15:2] == gpio_pkg::IDX_ANALOG_CTRL)
         |=> r_q.analog_dis == $past(writedata_i[gpio_pkg::ANALOG_DIS_BIT]))
      else $error("analog disable flag write lost");
endmodule

// [pin_board.sv]
// board model of one eight-bit port: device drive, outside source and pull-ups
`timescale 1ns/1ns
module pin_board (
   input wire logic [7:0] drive_i, // device drive level
   input wire logic [7:0] oe_n_i, // device enables, low drives
   input wire logic [7:0] src_i, // outside source level
   input wire logic [7:0] src_en_i, // outside source active
   output logic [7:0] pin_o // resolved wire level
);
   // the source backs off where the device drives, so the model never shows a short;
   // an undriven line floats up to its pull-up rather than keeping an old value
   always_comb begin
      for (int b = 0; b < 8; b++) begin
         if (oe_n_i[b] == 1'b0) begin
            pin_o[b] = drive_i[b];
         end else if (src_en_i[b] == 1'b1) begin
            pin_o[b] = src_i[b];
         end else begin
            pin_o[b] = 1'b1;
         end
      end
   end
endmodule

// [gpio_ports_four_to_six_tb.sv]
// self-checking bench for the port four to six block
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin bad_count++; \
   $display("Error t=%0t got %h exp %h", $time, (got), (exp)); end end
module gpio_ports_four_to_six_tb;
   logic core_clk_i = 1'b0;
   logic srst_i = 1'b1;
   logic [15:0] address_i = 16'h0000;
   logic read_i = 1'b0;
   logic write_i = 1'b0;
   logic [31:0] writedata_i = 32'h0000_0000;
   logic [3:0] byteenable_i = 4'h0;
   logic [31:0] readdata_o;
   logic waitrequest_o;
   logic [7:0] drv [3];
   logic [7:0] oen [3];
   logic [7:0] pin [3];
   logic [7:0] port4_in_o;
   logic [7:0] analog_input_sel_o;
   logic emergency_stop_two_o;
   logic analog_input_disable_o;
   // outside sources and shared-function inputs
   logic [7:0] src [3] = '{default: 8'h00};
   logic [7:0] sen [3] = '{default: 8'h00};
   logic [7:0] fe [3] = '{default: 8'h00};
   logic [7:0] fv [3] = '{default: 8'h00};
   // register state the bench expects
   logic [7:0] lat [3];
   logic [7:0] dir [3];
   logic [7:0] drn [3];
   logic adis;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;

   always #5 core_clk_i = ~core_clk_i;

   gpio_ports_four_to_six i_gpio_ports_four_to_six (
      .core_clk_i(core_clk_i), .srst_i(srst_i), .address_i(address_i), .read_i(read_i),
      .write_i(write_i), .writedata_i(writedata_i), .byteenable_i(byteenable_i),
      .readdata_o(readdata_o), .waitrequest_o(waitrequest_o),
      .port4_pin_i(pin[0]), .port4_pin_o(drv[0]), .port4_pin_oe_n_o(oen[0]),
      .port4_func_en_i(fe[0]), .port4_func_i(fv[0]), .port4_in_o(port4_in_o),
      .port5_pin_i(pin[1]), .port5_pin_o(drv[1]), .port5_pin_oe_n_o(oen[1]),
      .motor_control_output_en_i(fe[1]), .motor_control_output_i(fv[1]),
      .emergency_stop_two_o(emergency_stop_two_o),
      .port6_pin_i(pin[2]), .port6_pin_o(drv[2]), .port6_pin_oe_n_o(oen[2]),
      .debug_output_one_en_i(fe[2][7]), .debug_output_one_i(fv[2][7]),
      .analog_input_sel_o(analog_input_sel_o), .analog_input_disable_o(analog_input_disable_o)
   );

   // one board model per port
   for (genvar p = 0; p < 3; p++) begin : g_board
      pin_board i_pin_board (.drive_i(drv[p]), .oe_n_i(oen[p]), .src_i(src[p]), .src_en_i(sen[p]),
         .pin_o(pin[p]));
   end

   // hang guard, far above the roughly 3000 cycles the run needs
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         print_verdict();
      end
   end

   function automatic logic [7:0] exp_out(input logic [7:0] l, input logic [7:0] e, input logic [7:0] f);
      return l & (~e | f);
   endfunction

   function automatic logic [7:0] exp_oen(input logic [7:0] d, input logic [7:0] r, input logic [7:0] o);
      return ~(d & (~r | ~o));
   endfunction

   task automatic print_verdict();
      $display("comparisons %0d, mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // one avalon transfer; request held until waitrequest is seen low
   task automatic bus(input logic wr, input logic [13:0] idx, input logic [7:0] wd, input logic [3:0] be,
                      output logic [7:0] rd);
      @(posedge core_clk_i);
      address_i <= {idx, 2'b00};
      writedata_i <= {24'h000000, wd};
      byteenable_i <= be;
      write_i <= wr;
      read_i <= ~wr;
      @(posedge core_clk_i);
      while (waitrequest_o !== 1'b0) begin
         @(posedge core_clk_i);
      end
      rd = readdata_o[7:0];
      write_i <= 1'b0;
      read_i <= 1'b0;
   endtask

   task automatic wr(input logic [13:0] idx, input logic [7:0] v);
      logic [7:0] rd;
      bus(1'b1, idx, v, 4'h1, rd);
   endtask

   task automatic set_rst();
      for (int p = 0; p < 3; p++) begin
         lat[p] = 8'h00;
         dir[p] = 8'h00;
         drn[p] = 8'h00;
      end
      adis = 1'b1;
   endtask

   // compare every port output and every readable register with the bench's state
   task automatic check_all();
      logic [7:0] o [3];
      logic [7:0] n [3];
      logic [7:0] w [3];
      logic [13:0] ix [11];
      logic [7:0] ex [11];
      logic [7:0] rd;
      repeat (4) @(posedge core_clk_i);
      @(negedge core_clk_i);
      for (int p = 0; p < 3; p++) begin
         o[p] = exp_out(lat[p], fe[p], fv[p]);
         n[p] = exp_oen(dir[p], drn[p], o[p]);
         w[p] = (~n[p] & o[p]) | (n[p] & ~sen[p]) | (n[p] & sen[p] & src[p]);
         `CHK(drv[p], o[p])
         `CHK(oen[p], n[p])
      end
      `CHK(analog_input_sel_o, ~dir[2] & ~lat[2] & {8{~adis}})
      `CHK(analog_input_disable_o, adis)
      `CHK(port4_in_o, w[0])
      `CHK(emergency_stop_two_o, w[1][1])
      ix = '{gpio_pkg::IDX_PORT4_LATCH, gpio_pkg::IDX_PORT5_LATCH, gpio_pkg::IDX_PORT6_LATCH,
             gpio_pkg::IDX_PORT4_RMW, gpio_pkg::IDX_PORT5_RMW, gpio_pkg::IDX_PORT4_DRAIN,
             gpio_pkg::IDX_PORT5_DRAIN, gpio_pkg::IDX_PORT4_DIR, gpio_pkg::IDX_PORT5_DIR,
             gpio_pkg::IDX_PORT6_DIR, gpio_pkg::IDX_ANALOG_CTRL};
      ex = '{w[0], w[1], w[2] & (dir[2] | lat[2]), (drn[0] & lat[0]) | (~drn[0] & w[0]),
             (drn[1] & lat[1]) | (~drn[1] & w[1]), drn[0], drn[1], dir[0], dir[1], dir[2], {7'h00, adis}};
      for (int k = 0; k < 11; k++) begin
         bus(1'b0, ix[k], 8'h00, 4'h1, rd);
         `CHK(rd, ex[k])
      end
   endtask

   initial begin
      logic [7:0] rd;
      void'($urandom(32'h78d3c3b7));
      set_rst();
      repeat (6) @(posedge core_clk_i);
      srst_i <= 1'b0;
      check_all();
      // random port settings, pin levels and shared-function traffic
      for (int it = 0; it < 40; it++) begin
         @(posedge core_clk_i);
         for (int p = 0; p < 3; p++) begin
            src[p] <= 8'($urandom);
            sen[p] <= 8'($urandom);
            fv[p] <= 8'($urandom);
         end
         fe[0] <= 8'($urandom);
         fe[1] <= 8'($urandom);
         fe[2] <= {1'($urandom), 7'h00};
         for (int p = 0; p < 2; p++) begin
            lat[p] = 8'($urandom);
            dir[p] = 8'($urandom);
            drn[p] = 8'($urandom);
         end
         lat[2] = 8'($urandom);
         adis = 1'($urandom);
         dir[2] = 8'($urandom) & (lat[2] | {8{adis}});
         wr(gpio_pkg::IDX_PORT4_LATCH, lat[0]);
         // timer owning bit seven needs it in output mode
         dir[0][7] = dir[0][7] | fe[0][7];
         wr(gpio_pkg::IDX_PORT4_DIR, dir[0]);
         wr(gpio_pkg::IDX_PORT4_DRAIN, drn[0]);
         wr(gpio_pkg::IDX_PORT5_LATCH, lat[1]);
         wr(gpio_pkg::IDX_PORT5_DIR, dir[1]);
         wr(gpio_pkg::IDX_PORT5_DRAIN, drn[1]);
         // stop any conversion before touching port six
         wr(gpio_pkg::IDX_ANALOG_CTRL, 8'h01);
         wr(gpio_pkg::IDX_PORT6_LATCH, lat[2]);
         wr(gpio_pkg::IDX_PORT6_DIR, dir[2]);
         wr(gpio_pkg::IDX_ANALOG_CTRL, {7'h00, adis});
         check_all();
      end
      // writes that must leave every register alone
      bus(1'b1, gpio_pkg::IDX_PORT5_LATCH, ~lat[1], 4'h0, rd);
      bus(1'b1, gpio_pkg::IDX_PORT5_RMW, ~lat[1], 4'h1, rd);
      bus(1'b1, 14'h0100, 8'hff, 4'h1, rd);
      bus(1'b0, 14'h0100, 8'h00, 4'h1, rd);
      `CHK(rd, 8'h00)
      check_all();
      // second reset in mid-run returns everything to inputs
      @(posedge core_clk_i);
      srst_i <= 1'b1;
      repeat (2) @(posedge core_clk_i);
      srst_i <= 1'b0;
      set_rst();
      check_all();
      print_verdict();
   end
endmodule
